// File: eeprom_host.sv
`include "eeprom_host_defs.svh"
`default_nettype none
module eeprom_host #(
    parameter logic [2:0] VARIANT = 3'h0,
    parameter int READY_CYC = `SUPPLY_READY_DELAY_CYC
) (
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic cmdValid,
    input wire logic [1:0] cmdOp,
    input wire logic [12:0] cmdAddr,
    input wire logic [5:0] cmdLen,
    input wire logic [7:0] wrData,
    output logic wrTake,
    output logic [7:0] rdData,
    output logic rdValid,
    output logic busy,
    output logic cmdDone,
    output logic sclOut,
    output logic sclOe,
    input wire logic sdaIn,
    output logic sdaOut,
    output logic sdaOe
);
    localparam int QC = `SCL_QUARTER_CYC;
    eeprom_host_pkg::state_t st_r, st_nxt;
    logic [1:0] sdaSync_r;
    logic [7:0] qcnt_r, qcnt_nxt;
    logic [1:0] ph_r, ph_nxt;
    logic [3:0] bit_r, bit_nxt;
    logic [7:0] sh_r, sh_nxt;
    logic [2:0] byteIdx_r, byteIdx_nxt;
    logic [5:0] left_r, left_nxt;
    logic [1:0] op_r, op_nxt;
    logic [12:0] addr_r, addr_nxt;
    logic [5:0] len_r, len_nxt;
    logic readPhase_r, readPhase_nxt;
    logic [15:0] pu_r, pu_nxt;
    logic scl_r, scl_nxt, sdaLow_r, sdaLow_nxt;
    logic wrTake_r, wrTake_nxt, rdValid_r, rdValid_nxt, done_r, done_nxt;
    logic busy_r, busy_nxt;
    logic [7:0] rd_r, rd_nxt;
    logic tick;
    wire logic sdaS = sdaSync_r[1];

    assign tick = (qcnt_r == 8'(QC - 1));

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            sdaSync_r <= 2'h3;
        end else begin
            sdaSync_r <= {sdaSync_r[0], sdaIn};
        end
    end

    // The address byte for this build: fixed prefix, variant bits, direction.
    function automatic logic [7:0] devByte(input logic rd);
        devByte = {`ADDR_PREFIX, VARIANT, rd};
    endfunction

    always_comb begin
        st_nxt = st_r;
        qcnt_nxt = tick ? 8'h00 : 8'(qcnt_r + 8'h01);
        ph_nxt = ph_r;
        bit_nxt = bit_r;
        sh_nxt = sh_r;
        byteIdx_nxt = byteIdx_r;
        left_nxt = left_r;
        op_nxt = op_r;
        addr_nxt = addr_r;
        len_nxt = len_r;
        readPhase_nxt = readPhase_r;
        pu_nxt = (pu_r != 16'h0000) ? 16'(pu_r - 16'h0001) : pu_r;
        scl_nxt = scl_r;
        sdaLow_nxt = sdaLow_r;
        wrTake_nxt = 1'b0;
        rdValid_nxt = 1'b0;
        done_nxt = 1'b0;
        rd_nxt = rd_r;
        if (st_r == eeprom_host_pkg::ST_IDLE) begin
            qcnt_nxt = 8'h00;
            ph_nxt = 2'h0;
            // Commands wait out the supply ready delay and an idle bus.
            if (cmdValid && pu_r == 16'h0000 && sdaS) begin
                op_nxt = cmdOp;
                addr_nxt = cmdAddr;
                len_nxt = (cmdLen == 6'h00) ? 6'h01 : cmdLen;
                readPhase_nxt = (cmdOp == eeprom_host_pkg::OP_READ_CUR);
                st_nxt = eeprom_host_pkg::ST_START;
            end
        end else if (tick) begin
            ph_nxt = 2'(ph_r + 2'h1);
            case (st_r)
                eeprom_host_pkg::ST_START, eeprom_host_pkg::ST_RESTART: begin
                    // Data falls while the clock is high.
                    case (ph_r)
                        2'h0: begin
                            sdaLow_nxt = 1'b0;
                            scl_nxt = 1'b0;
                        end
                        2'h1: scl_nxt = 1'b1;
                        2'h2: sdaLow_nxt = 1'b1;
                        default: begin
                            scl_nxt = 1'b0;
                            byteIdx_nxt = 3'h0;
                            bit_nxt = 4'h0;
                            sh_nxt = devByte(readPhase_r);
                            st_nxt = eeprom_host_pkg::ST_SEND;
                        end
                    endcase
                end
                eeprom_host_pkg::ST_SEND, eeprom_host_pkg::ST_GETACK, eeprom_host_pkg::ST_RECV,
                eeprom_host_pkg::ST_PUTACK: begin
                    case (ph_r)
                        2'h0: begin
                            // Data changes only while the clock is low.
                            if (st_r == eeprom_host_pkg::ST_SEND) sdaLow_nxt = ~sh_r[7];
                            else if (st_r == eeprom_host_pkg::ST_PUTACK) sdaLow_nxt = (left_r != 6'h01);
                            else sdaLow_nxt = 1'b0;
                        end
                        2'h1: scl_nxt = 1'b1;
                        2'h2: begin
                            if (st_r == eeprom_host_pkg::ST_RECV) sh_nxt = {sh_r[6:0], sdaS};
                            if (st_r == eeprom_host_pkg::ST_GETACK && sdaS) begin
                                // Refused: device busy or absent; the STOP waits until the clock is low again.
                                readPhase_nxt = (op_r == eeprom_host_pkg::OP_READ_CUR);
                                byteIdx_nxt = 3'h7;
                            end
                        end
                        default: begin
                            scl_nxt = 1'b0;
                            if (st_r == eeprom_host_pkg::ST_SEND) begin
                                sh_nxt = {sh_r[6:0], 1'b1};
                                bit_nxt = 4'(bit_r + 4'h1);
                                if (bit_r == 4'h7) st_nxt = eeprom_host_pkg::ST_GETACK;
                            end else if (st_r == eeprom_host_pkg::ST_RECV) begin
                                bit_nxt = 4'(bit_r + 4'h1);
                                if (bit_r == 4'h7) begin
                                    st_nxt = eeprom_host_pkg::ST_PUTACK;
                                    rd_nxt = sh_r;
                                    rdValid_nxt = 1'b1;
                                end
                            end else if (st_r == eeprom_host_pkg::ST_PUTACK) begin
                                bit_nxt = 4'h0;
                                left_nxt = 6'(left_r - 6'h01);
                                st_nxt = (left_r == 6'h01) ? eeprom_host_pkg::ST_STOP : eeprom_host_pkg::ST_RECV;
                            end else if (st_r == eeprom_host_pkg::ST_GETACK && byteIdx_r == 3'h7) begin
                                // A STOP frees the bus before the whole request is retried.
                                st_nxt = eeprom_host_pkg::ST_STOP;
                            end else if (st_r == eeprom_host_pkg::ST_GETACK && byteIdx_r != 3'h7) begin
                                bit_nxt = 4'h0;
                                // Data bytes all share index three, so a long page never reaches the refusal mark.
                                byteIdx_nxt = (byteIdx_r == 3'h3) ? 3'h3 : 3'(byteIdx_r + 3'h1);
                                if (readPhase_r) begin
                                    left_nxt = len_r;
                                    st_nxt = eeprom_host_pkg::ST_RECV;
                                end else if (byteIdx_r == 3'h0) begin
                                    sh_nxt = {3'h0, addr_r[12:8]};
                                    st_nxt = eeprom_host_pkg::ST_SEND;
                                end else if (byteIdx_r == 3'h1) begin
                                    sh_nxt = addr_r[7:0];
                                    left_nxt = len_r;
                                    st_nxt = eeprom_host_pkg::ST_SEND;
                                end else if (op_r == eeprom_host_pkg::OP_READ_SEL) begin
                                    readPhase_nxt = 1'b1;
                                    st_nxt = eeprom_host_pkg::ST_RESTART;
                                end else if (left_r != 6'h00) begin
                                    // Host does not cap at one page; runs longer than 32 bytes would wrap in the device.
                                    sh_nxt = wrData;
                                    wrTake_nxt = 1'b1;
                                    left_nxt = 6'(left_r - 6'h01);
                                    st_nxt = eeprom_host_pkg::ST_SEND;
                                end else begin
                                    st_nxt = eeprom_host_pkg::ST_STOP;
                                end
                            end
                        end
                    endcase
                end
                eeprom_host_pkg::ST_STOP: begin
                    case (ph_r)
                        2'h0: sdaLow_nxt = 1'b1;
                        2'h1: scl_nxt = 1'b1;
                        2'h2: sdaLow_nxt = 1'b0;
                        default: begin
                            if (byteIdx_r == 3'h7) begin
                                st_nxt = eeprom_host_pkg::ST_START;
                            end else begin
                                st_nxt = eeprom_host_pkg::ST_DONE;
                                done_nxt = 1'b1;
                            end
                        end
                    endcase
                end
                default: st_nxt = eeprom_host_pkg::ST_IDLE;
            endcase
        end
        busy_nxt = (st_nxt != eeprom_host_pkg::ST_IDLE);
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            st_r <= eeprom_host_pkg::ST_IDLE;
            qcnt_r <= 8'h00;
            ph_r <= 2'h0;
            bit_r <= 4'h0;
            sh_r <= 8'h00;
            byteIdx_r <= 3'h0;
            left_r <= 6'h00;
            op_r <= 2'h0;
            addr_r <= 13'h0000;
            len_r <= 6'h00;
            readPhase_r <= 1'b0;
            pu_r <= 16'(READY_CYC);
            scl_r <= 1'b1;
            sdaLow_r <= 1'b0;
            wrTake_r <= 1'b0;
            rdValid_r <= 1'b0;
            done_r <= 1'b0;
            rd_r <= 8'hFF;
            busy_r <= 1'b0;
        end else begin
            st_r <= st_nxt;
            qcnt_r <= qcnt_nxt;
            ph_r <= ph_nxt;
            bit_r <= bit_nxt;
            sh_r <= sh_nxt;
            byteIdx_r <= byteIdx_nxt;
            left_r <= left_nxt;
            op_r <= op_nxt;
            addr_r <= addr_nxt;
            len_r <= len_nxt;
            readPhase_r <= readPhase_nxt;
            pu_r <= pu_nxt;
            scl_r <= scl_nxt;
            sdaLow_r <= sdaLow_nxt;
            wrTake_r <= wrTake_nxt;
            rdValid_r <= rdValid_nxt;
            done_r <= done_nxt;
            rd_r <= rd_nxt;
            busy_r <= busy_nxt;
        end
    end

    assign sclOut = 1'b0;
    assign sclOe = scl_r;
    assign sdaOut = 1'b0;
    assign sdaOe = ~sdaLow_r;
    assign wrTake = wrTake_r;
    assign rdValid = rdValid_r;
    assign rdData = rd_r;
    assign cmdDone = done_r;
    assign busy = busy_r;

    AST_SDA_STABLE: assert property (@(posedge mclk) disable iff (!rst_n)
        (scl_r && $past(scl_r) && (st_r == eeprom_host_pkg::ST_SEND || st_r == eeprom_host_pkg::ST_GETACK
        || st_r == eeprom_host_pkg::ST_RECV || st_r == eeprom_host_pkg::ST_PUTACK)) |-> $stable(sdaLow_r))
        else $error("Data changed while clock high.");
    AST_START_FORM: assert property (@(posedge mclk) disable iff (!rst_n)
        ($rose(sdaLow_r) && scl_r) |-> (st_r == eeprom_host_pkg::ST_START || st_r == eeprom_host_pkg::ST_RESTART))
        else $error("Data fell under high clock outside start.");
    AST_STOP_FORM: assert property (@(posedge mclk) disable iff (!rst_n)
        ($fell(sdaLow_r) && scl_r) |-> (st_r == eeprom_host_pkg::ST_STOP))
        else $error("Data rose under high clock outside stop.");
    AST_NO_EARLY_CMD: assert property (@(posedge mclk) disable iff (!rst_n)
        (pu_r != 16'h0000) |-> (st_r == eeprom_host_pkg::ST_IDLE))
        else $error("Command before supply ready delay.");
    AST_ACK_RELEASE: assert property (@(posedge mclk) disable iff (!rst_n)
        (st_r == eeprom_host_pkg::ST_GETACK && scl_r) |-> !sdaLow_r)
        else $error("Host drove data during acknowledge slot.");
    AST_RD_NACK_LAST: assert property (@(posedge mclk) disable iff (!rst_n)
        (st_r == eeprom_host_pkg::ST_PUTACK && scl_r && left_r == 6'h01) |-> !sdaLow_r)
        else $error("Last read byte was acknowledged.");
    AST_RD_ACK_MORE: assert property (@(posedge mclk) disable iff (!rst_n)
        (st_r == eeprom_host_pkg::ST_PUTACK && scl_r && left_r > 6'h01) |-> sdaLow_r)
        else $error("Middle read byte not acknowledged.");
    AST_SCL_PERIOD: assert property (@(posedge mclk) disable iff (!rst_n)
        $rose(scl_r) |-> scl_r [*8])
        else $error("Clock high phase too short.");
    AST_REFUSE_RETRY: assert property (@(posedge mclk) disable iff (!rst_n)
        (st_r == eeprom_host_pkg::ST_STOP && byteIdx_r == 3'h7 && tick && ph_r == 2'h3)
        |=> (st_r == eeprom_host_pkg::ST_START))
        else $error("Refused request not retried.");
endmodule
`default_nettype wire

// File: eeprom_host_defs.svh
`ifndef EEPROM_HOST_DEFS_SVH
`define EEPROM_HOST_DEFS_SVH
// Bus timing: the host makes the serial clock by dividing mclk.
`define CLK_PERIOD_NS 25
`define SCL_QUARTER_NS 250
`define SCL_QUARTER_CYC ((`SCL_QUARTER_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define SUPPLY_READY_DELAY_US 350
`define SUPPLY_READY_DELAY_CYC ((`SUPPLY_READY_DELAY_US * 1000 + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define ADDR_PREFIX 4'hA
`define ADDR_PREFIX_W 4
`define MEM_ADDR_W 13
`define PAGE_BYTES 32
`endif

// File: eeprom_host_pkg.sv
`default_nettype none
package eeprom_host_pkg;
    typedef enum logic [3:0] {
        ST_IDLE = 4'h0,
        ST_START = 4'h1,
        ST_SEND = 4'h3,
        ST_GETACK = 4'h2,
        ST_RECV = 4'h6,
        ST_PUTACK = 4'h7,
        ST_STOP = 4'h5,
        ST_RESTART = 4'h4,
        ST_DONE = 4'hC
    } state_t;
    typedef enum logic [1:0] {
        OP_WRITE = 2'h0,
        OP_READ_CUR = 2'h1,
        OP_READ_SEL = 2'h2
    } op_t;
endpackage
`default_nettype wire

// File: eeprom_slave_model.sv
`default_nettype none
module eeprom_slave_model #(
    parameter logic [2:0] VARIANT = 3'h0,
    parameter int PROG_NS = 20000,
    parameter int READY_NS = 300
) (
    input wire logic scl,
    input wire logic sda,
    output logic sdaLow
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [7:0] mem [8192];
    logic [7:0] sr, pend [32];
    logic [31:0] pendVal = '0;
    logic [12:0] addr = '0;
    int cnt = 0, phase = 0;
    logic active = 1'b0, reading = 1'b0, mAck = 1'b0, progBusy = 1'b0, ready = 1'b0;
    initial begin
        sdaLow = 1'b0;
        foreach (mem[i]) mem[i] = 8'hFF;
        #(READY_NS) ready = 1'b1;
    end
    always @(negedge sda) begin
        if (scl === 1'b1) begin
            active = ready;
            cnt = 0;
            phase = 0;
            reading = 1'b0;
        end
    end
    // The page lands in one go; offsets never sent keep their old contents.
    always @(posedge sda) begin
        if (scl === 1'b1) begin
            active = 1'b0;
            if (pendVal != '0) begin
                foreach (pend[i]) if (pendVal[i]) mem[{addr[12:5], 5'(i)}] = pend[i];
                pendVal = '0;
                progBusy = 1'b1;
                progBusy <= #(PROG_NS) 1'b0;
            end
        end
    end
    always @(posedge scl) begin
        if (active && cnt < 8 && !reading) sr = {sr[6:0], sda};
        if (active && cnt == 8) mAck = !sda;
        if (active) cnt = cnt + 1;
    end
    always @(negedge scl) begin
        if (active) sdaLow = 1'b0;
        if (active && cnt == 8 && !reading) begin
            if (phase == 0 && (sr[7:4] != 4'hA || sr[3:1] != VARIANT || progBusy)) active = 1'b0;
            sdaLow = active;
            if (phase == 0) reading = sr[0];
            if (phase == 1) addr[12:8] = sr[4:0];
            if (phase == 2) addr[7:0] = sr;
            if (phase == 3) begin
                pend[addr[4:0]] = sr;
                pendVal[addr[4:0]] = 1'b1;
                addr[4:0] = addr[4:0] + 5'h01;
            end
            if (phase < 3) phase = phase + 1;
        end else if (active && cnt == 9) begin
            cnt = 0;
            if (reading && mAck) begin
                sr = mem[addr];
                addr = addr + 13'h0001;
            end
            active = !reading || mAck;
        end
        if (active && reading && cnt < 8) sdaLow = !sr[7 - cnt];
    end
endmodule
`default_nettype wire

// File: test_eeprom_host.sv
`default_nettype none
module test_eeprom_host;
    timeunit 1ns;
    timeprecision 100ps;
    typedef logic [7:0] bytes_t [$];
    localparam int READY = 20;
    logic mclk = 1'b0, rst_n = 1'b0, cmdValid = 1'b0;
    logic [1:0] cmdOp = 2'h0;
    logic [12:0] cmdAddr = 13'h0000;
    logic [5:0] cmdLen = 6'h01;
    logic [7:0] wrData = 8'h00, rdData;
    logic wrTake, rdValid, busy, cmdDone, sclOut, sclOe, sdaOut, sdaOe, sdaLow, scl, sda;
    bytes_t wq, rq, big;
    int n_mismatch = 0, checks = 0, took = 0;
    // Both lines are pulled up, so a released pin reads high.
    assign scl = sclOe ? 1'b1 : sclOut;
    assign sda = (sdaOe ? 1'b1 : sdaOut) & !sdaLow;
    always #12.5 mclk = ~mclk;
    eeprom_host #(.VARIANT(3'h4), .READY_CYC(READY)) u_eeprom_host (.mclk(mclk), .rst_n(rst_n),
        .cmdValid(cmdValid), .cmdOp(cmdOp), .cmdAddr(cmdAddr), .cmdLen(cmdLen), .wrData(wrData),
        .wrTake(wrTake), .rdData(rdData), .rdValid(rdValid), .busy(busy), .cmdDone(cmdDone),
        .sclOut(sclOut), .sclOe(sclOe), .sdaIn(sda), .sdaOut(sdaOut), .sdaOe(sdaOe));
    eeprom_slave_model #(.VARIANT(3'h4)) u_eeprom_slave_model (.scl(scl), .sda(sda), .sdaLow(sdaLow));
    always @(posedge mclk) begin
        if (rdValid === 1'b1) rq.push_back(rdData);
        if (wrTake === 1'b1 && wq.size() > 0) void'(wq.pop_front());
        #2 wrData = (wq.size() > 0) ? wq[0] : 8'h00;
    end
    task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string what);
        checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED at %0t: %s seen %h expected %h", $time, what, seen, exp);
        end
    endtask
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", checks, n_mismatch);
        if (n_mismatch == 0 && checks > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    // A write expects every byte to be taken; a read expects the bytes back in order.
    task automatic xfer(input logic [1:0] op, input logic [12:0] addr, input bytes_t data);
        int n;
        if (op == 2'h0) wq = data;
        rq.delete();
        @(posedge mclk);
        #2;
        // The host stays busy for a quarter after cmdDone and ignores requests until it is idle.
        for (n = 0; n < 100 && busy !== 1'b0; n++) begin
            @(posedge mclk);
            #2;
        end
        cmdOp = op;
        cmdAddr = addr;
        cmdLen = 6'(data.size());
        cmdValid = 1'b1;
        for (took = 0; took < 2000 && busy !== 1'b1; took++) begin
            @(posedge mclk);
            #2;
        end
        cmdValid = 1'b0;
        for (n = 0; n < 40000 && cmdDone !== 1'b1; n++) begin
            @(posedge mclk);
            #2;
        end
        check(16'(cmdDone), 16'h0001, "done");
        if (op == 2'h0) check(16'(wq.size()), 16'h0000, "write count");
        for (n = 0; op != 2'h0 && n < data.size(); n++) check(16'(rq[n]), 16'(data[n]), "read");
        if (op != 2'h0) check(16'(rq.size()), 16'(data.size()), "read count");
    endtask
    task automatic test_reset();
        repeat (8) @(posedge mclk);
        check({rdData, sclOe, sdaOe, sclOut, sdaOut, busy, wrTake, rdValid, cmdDone}, 16'hFFC0, "reset");
        repeat (8) @(posedge mclk);
        #2 rst_n = 1'b1;
        xfer(2'h2, 13'h0005, '{8'hFF});
        check(16'(took >= READY - 2 && took <= READY + 6), 16'h0001, "ready delay");
        $display("test_reset done");
    endtask
    task automatic test_memory();
        xfer(2'h0, 13'h001E, '{8'hA1, 8'hB2, 8'hC3});
        xfer(2'h2, 13'h001E, '{8'hA1, 8'hB2, 8'hFF});
        xfer(2'h2, 13'h0000, '{8'hC3});
        for (int i = 0; i < 32; i++) big.push_back(8'(8'h40 + i));
        xfer(2'h0, 13'h0040, big);
        xfer(2'h2, 13'h0040, big);
        xfer(2'h0, 13'h1FFF, '{8'h5A});
        xfer(2'h2, 13'h1FFF, '{8'h5A});
        xfer(2'h1, 13'h0000, '{8'hC3});
        $display("test_memory done");
    endtask
    initial begin
        test_reset();
        test_memory();
        tally_and_finish();
    end
    initial begin
        #1500000;
        n_mismatch++;
        $display("CHECK FAILED at %0t: watchdog expired", $time);
        tally_and_finish();
    end
endmodule
`default_nettype wire
